//--- hdl/adcpc_defines.vh
`ifndef ADCPC_DEFINES_VH
`define ADCPC_DEFINES_VH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define ADCPC_ADDR_W 8
`define ADCPC_OFS_SC 8'h00
`define ADCPC_OFS_RESHI 8'h04
`define ADCPC_OFS_RESLO 8'h08
`define ADCPC_OFS_CLK 8'h0C
`define ADCPC_OFS_BFC 8'h10

// ----------------------------------------------------------------
// status/control fields
// ----------------------------------------------------------------
`define ADCPC_CH_LSB 0
`define ADCPC_CH_MSB 4
`define ADCPC_CONT_BIT 5
`define ADCPC_IEN_BIT 6
`define ADCPC_DONE_BIT 7
`define ADCPC_CH_OFF 5'h1F
`define ADCPC_CH_RST 5'h1F

// ----------------------------------------------------------------
// clock register and break flag control fields
// ----------------------------------------------------------------
`define ADCPC_ACLK_BIT 0
`define ADCPC_MODE_LSB 1
`define ADCPC_MODE_MSB 2
`define ADCPC_MODE_HWTRIG 2'h3
`define ADCPC_MODE_RST 2'h0
`define ADCPC_BCE_BIT 0

// ----------------------------------------------------------------
// result layout and bus answers
// ----------------------------------------------------------------
`define ADCPC_RES_W 10
`define ADCPC_RESLO_MSB 7
`define ADCPC_RESHI_LSB 8
`define ADCPC_RESHI_MSB 9
`define ADCPC_RES_RST 10'h000
`define ADCPC_RESP_OKAY 2'h0
`define ADCPC_RESP_SLVERR 2'h2
`define ADCPC_SYNC_W 13
`define ADCPC_HW_TRIGGER 1'b0

`endif

//--- hdl/adcpc_sync2.v
`timescale 1ns/1ps
`include "adcpc_defines.vh"

// ----------------------------------------------------------------
// two-stage synchroniser for the pin-side inputs
// ----------------------------------------------------------------
module adcpc_sync2 (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // data
  input wire [`ADCPC_SYNC_W-1:0] asyncIn,
  output reg [`ADCPC_SYNC_W-1:0] syncOut
);

  reg [`ADCPC_SYNC_W-1:0] stage1;

  always @(posedge mclk) begin
    if (!reset_n) begin
      stage1 <= {`ADCPC_SYNC_W{1'b0}};
      syncOut <= {`ADCPC_SYNC_W{1'b0}};
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule // adcpc_sync2

//--- hdl/adcpc_top.v
// Contract
// R1 - irq enable set: interrupt at each conversion end, with done flag
// R2 - done flag set at every conversion end, whatever irq enable says
// R3 - in wait mode keep converting and still interrupt when enabled
// R4 - single mode drops to low power by itself after the conversion
// R5 - software clears continuous bit before wait if no wakeup is wanted
// R6 - async clock off: stop entry aborts conversion, enters low power
// R7 - after such a stop stay idle until software writes status/control
// R8 - after a stop abort results keep the last completed conversion
// R9 - async clock on: conversions and interrupts continue through stop
// R10 - software clears continuous bit before stop if no wakeup is wanted
// R11 - stop, async clock, hardware mode: wait for trigger, convert once
// R12 - no external trigger source; hardware trigger held inactive
// R13 - break clear enable 1: software clears in break take effect, persist
// R14 - break clear enable 0: accesses in break leave status flags unchanged
// R15 - two-step clear: first step kept through protected break, second clears; the done flag here has a one-step clear
// R16 - status/control write aborts and restarts unless channel is all ones
// R17 - done flag cleared by status/control write or result low read
// R18 - interrupt output is done flag AND irq enable, held until clear
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "adcpc_defines.vh"

module adcpc_top (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // axi4-lite write address
  input wire [`ADCPC_ADDR_W-1:0] awaddr,
  input wire [2:0] awprot,
  input wire awvalid,
  output reg awready,
  // axi4-lite write data
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  // axi4-lite write response
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read address
  input wire [`ADCPC_ADDR_W-1:0] araddr,
  input wire [2:0] arprot,
  input wire arvalid,
  output reg arready,
  // axi4-lite read data
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // system state
  input wire stopMode,
  input wire breakState,
  // converter core
  input wire coreDone,
  input wire [`ADCPC_RES_W-1:0] coreResult,
  output reg coreStart,
  output reg coreAbort,
  output reg coreLowPower,
  output reg [4:0] coreChannel,
  // interrupt
  output reg irq
);

  // ----------------------------------------------------------------
  // states and helpers
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'b001, ST_CONV = 3'b010, ST_HALT = 3'b100;

  function chanOff(input [4:0] ch);
    chanOff = (ch == `ADCPC_CH_OFF);
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  wire [`ADCPC_SYNC_W-1:0] syncBus;
  wire stopSync, breakSync, doneSync;
  wire [`ADCPC_RES_W-1:0] resultSync;
  reg doneSeen;

  adcpc_sync2 u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .asyncIn({stopMode, breakState, coreDone, coreResult}),
    .syncOut(syncBus)
  );

  assign stopSync = syncBus[`ADCPC_SYNC_W-1];
  assign breakSync = syncBus[`ADCPC_SYNC_W-2];
  assign doneSync = syncBus[`ADCPC_SYNC_W-3];
  assign resultSync = syncBus[`ADCPC_RES_W-1:0];

  // core holds its result stable while done is high
  wire doneRise = doneSync & ~doneSeen;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [4:0] channel;
  reg contBit, ienBit, doneFlag, async_clock_enable, bceBit;
  reg [`ADCPC_RES_W-1:0] result;
  reg [1:0] convMode;
  reg [2:0] state;

  // ----------------------------------------------------------------
  // axi4-lite slave: one write and one read at a time
  // ----------------------------------------------------------------
  reg [`ADCPC_ADDR_W-1:0] wrAddr;
  reg [7:0] wrByte;
  reg wrLane0;
  wire awFire = awvalid & awready;
  wire wFire = wvalid & wready;
  wire wrGo = ~awready & ~wready & ~bvalid;
  wire arFire = arvalid & arready;
  wire wrMapped = (wrAddr == `ADCPC_OFS_SC) |
    (wrAddr == `ADCPC_OFS_RESHI) | (wrAddr == `ADCPC_OFS_RESLO) |
    (wrAddr == `ADCPC_OFS_CLK) | (wrAddr == `ADCPC_OFS_BFC);
  wire scWrite = wrGo & wrLane0 & (wrAddr == `ADCPC_OFS_SC);
  wire loRead = arFire & (araddr == `ADCPC_OFS_RESLO);

  always @(posedge mclk) begin
    if (!reset_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= `ADCPC_RESP_OKAY;
      wrAddr <= {`ADCPC_ADDR_W{1'b0}};
      wrByte <= 8'h00;
      wrLane0 <= 1'b0;
    end else begin
      if (awFire) begin
        wrAddr <= awaddr;
        awready <= 1'b0;
      end
      if (wFire) begin
        wrByte <= wdata[7:0];
        wrLane0 <= wstrb[0];
        wready <= 1'b0;
      end
      if (wrGo) begin
        bvalid <= 1'b1;
        bresp <= wrMapped ? `ADCPC_RESP_OKAY : `ADCPC_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  reg [31:0] rdMux;
  reg rdErr;

  always @* begin
    rdMux = 32'h00000000;
    rdErr = 1'b0;
    case (araddr)
      `ADCPC_OFS_SC: begin
        rdMux[`ADCPC_CH_MSB:`ADCPC_CH_LSB] = channel;
        rdMux[`ADCPC_CONT_BIT] = contBit;
        rdMux[`ADCPC_IEN_BIT] = ienBit;
        rdMux[`ADCPC_DONE_BIT] = doneFlag;
      end
      `ADCPC_OFS_RESHI: begin
        rdMux[1:0] = result[`ADCPC_RESHI_MSB:`ADCPC_RESHI_LSB];
      end
      `ADCPC_OFS_RESLO: begin
        rdMux[7:0] = result[`ADCPC_RESLO_MSB:0];
      end
      `ADCPC_OFS_CLK: begin
        rdMux[`ADCPC_ACLK_BIT] = async_clock_enable;
        rdMux[`ADCPC_MODE_MSB:`ADCPC_MODE_LSB] = convMode;
      end
      `ADCPC_OFS_BFC: begin
        rdMux[`ADCPC_BCE_BIT] = bceBit;
      end
      default: begin
        rdErr = 1'b1;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `ADCPC_RESP_OKAY;
    end else begin
      if (arFire) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rdMux;
        rresp <= rdErr ? `ADCPC_RESP_SLVERR : `ADCPC_RESP_OKAY;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // software-written control bits
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (!reset_n) begin
      channel <= `ADCPC_CH_RST;
      contBit <= 1'b0;
      ienBit <= 1'b0;
      async_clock_enable <= 1'b0;
      convMode <= `ADCPC_MODE_RST;
      bceBit <= 1'b0;
    end else if (wrGo && wrLane0) begin
      case (wrAddr)
        `ADCPC_OFS_SC: begin
          channel <= wrByte[`ADCPC_CH_MSB:`ADCPC_CH_LSB];
          contBit <= wrByte[`ADCPC_CONT_BIT];
          ienBit <= wrByte[`ADCPC_IEN_BIT];
        end
        `ADCPC_OFS_CLK: begin
          async_clock_enable <= wrByte[`ADCPC_ACLK_BIT];
          convMode <= wrByte[`ADCPC_MODE_MSB:`ADCPC_MODE_LSB];
        end
        `ADCPC_OFS_BFC: begin
          bceBit <= wrByte[`ADCPC_BCE_BIT];
        end
        default: bceBit <= bceBit;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  // no trigger pin on this part: the request is a constant low
  wire hwTrig = `ADCPC_HW_TRIGGER; // [R12]
  wire stopKill = stopSync & ~async_clock_enable;
  wire [4:0] wrChan = wrByte[`ADCPC_CH_MSB:`ADCPC_CH_LSB];
  wire convEnd = (state == ST_CONV) & doneRise & ~stopKill;

  reg [2:0] next_state;
  reg next_start, next_abort;

  always @* begin
    next_state = state;
    next_start = 1'b0;
    next_abort = 1'b0;
    case (state)
      ST_IDLE: begin
        if (stopKill) begin
          next_state = ST_HALT; // [R6]
        end else if (scWrite && !chanOff(wrChan)) begin
          next_state = ST_CONV;
          next_start = 1'b1;
        end else if (stopSync && async_clock_enable && hwTrig &&
                     convMode == `ADCPC_MODE_HWTRIG) begin
          next_state = ST_CONV; // [R11]
          next_start = 1'b1;
        end
      end
      ST_CONV: begin
        if (stopKill) begin
          // result stays as the last completed conversion
          next_state = ST_HALT; // [R6] [R8]
          next_abort = 1'b1;
        end else if (scWrite) begin
          next_abort = 1'b1; // [R16]
          next_start = !chanOff(wrChan);
          next_state = chanOff(wrChan) ? ST_IDLE : ST_CONV;
        end else if (doneRise) begin
          // wait mode has no effect here; only stop can halt
          if (contBit && !chanOff(channel)) begin
            next_start = 1'b1; // [R3] [R9]
          end else begin
            next_state = ST_IDLE; // [R4]
          end
        end
      end
      ST_HALT: begin
        // continuous mode too needs a fresh write to resume
        if (!stopKill && scWrite && !chanOff(wrChan)) begin
          next_state = ST_CONV; // [R7]
          next_start = 1'b1;
        end else if (!stopKill && scWrite) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge mclk) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      coreStart <= 1'b0;
      coreAbort <= 1'b0;
      coreLowPower <= 1'b1;
      coreChannel <= `ADCPC_CH_RST;
      doneSeen <= 1'b0;
      result <= `ADCPC_RES_RST;
    end else begin
      state <= next_state;
      coreStart <= next_start;
      coreAbort <= next_abort;
      coreLowPower <= (next_state != ST_CONV); // [R4]
      if (scWrite)
        coreChannel <= wrChan;
      doneSeen <= doneSync;
      if (convEnd && !scWrite)
        result <= resultSync;
    end
  end

  // ----------------------------------------------------------------
  // done flag and interrupt
  // ----------------------------------------------------------------
  // break protects the flag unless clearing is enabled; the flag has a
  // one-step clear so no half-done sequence needs holding
  wire clrAllowed = ~breakSync | bceBit; // [R13] [R14] [R15]
  wire doneClr = (scWrite | loRead) & clrAllowed; // [R17]
  wire setDone = convEnd & ~scWrite;
  wire next_done = setDone | (doneFlag & ~doneClr); // [R2]
  wire next_ien = scWrite ? wrByte[`ADCPC_IEN_BIT] : ienBit;

  always @(posedge mclk) begin
    if (!reset_n) begin
      doneFlag <= 1'b0;
      irq <= 1'b0;
    end else begin
      doneFlag <= next_done;
      irq <= next_done & next_ien; // [R1] [R18]
    end
  end

endmodule // adcpc_top

//--- test/adcpc_top_assertions.sv
`timescale 1ns/1ps
`include "adcpc_defines.vh"

module adcpc_top_assertions (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // bus
  input wire [`ADCPC_ADDR_W-1:0] araddr,
  input wire arvalid,
  input wire arready,
  input wire rvalid,
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire bvalid,
  // system and core
  input wire breakState,
  input wire coreDone,
  input wire coreStart,
  input wire coreAbort,
  input wire coreLowPower,
  input wire irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ------------------------------------------------
  // steps of a completion and of its clearing
  // ------------------------------------------------
  // break is seen late through the synchroniser
  sequence rdLow;
    arvalid && arready && araddr == `ADCPC_OFS_RESLO && !breakState &&
      !$past(breakState) && !$past(breakState, 2);
  endsequence
  sequence doneSeen;
    $past(coreDone, 3);
  endsequence
  a_start_pulse: assert property (coreStart |=> !coreStart)
    else $error("start held past one cycle");
  a_abort_pulse: assert property (coreAbort |=> !coreAbort)
    else $error("abort held past one cycle");
  a_start_active: assert property (coreStart |-> !coreLowPower)
    else $error("start while in low power");
  a_abort_idle: assert property (
    coreAbort && !coreStart |-> coreLowPower)
    else $error("abort without low power");
  a_irq_cause: assert property ($rose(irq) |-> doneSeen)
    else $error("interrupt without a finished conversion");
  a_lowpow_cause: assert property (
    $rose(coreLowPower) |-> coreAbort || $past(coreDone, 3))
    else $error("low power entered without cause");
  a_irq_hold: assert property (
    irq && awready && !(arvalid || awvalid || rvalid) |=> irq)
    else $error("interrupt dropped without an access");
  a_read_clear: assert property (rdLow |-> ##[1:3] !irq)
    else $error("interrupt kept after low result read");
endmodule // adcpc_top_assertions

//--- test/adcpc_core_model.sv
`timescale 1ns/1ps

// converter core stand-in: done comes lat+1 cycles after a start
module adcpc_core_model (
  // clock and reset
  input wire mclk,
  input wire reset_n,
  // from the block
  input wire coreStart,
  input wire coreAbort,
  // bench settings
  input wire [7:0] lat,
  input wire [9:0] sample,
  // to the block
  output reg coreDone,
  output reg [9:0] coreResult
);
  reg busy;
  reg [7:0] cnt;
  always @(posedge mclk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      cnt <= 8'h00;
      coreDone <= 1'b0;
      coreResult <= 10'h000;
    end else if (coreStart || coreAbort) begin
      busy <= coreStart;
      cnt <= lat;
      coreDone <= 1'b0;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (busy) begin
      busy <= 1'b0;
      coreDone <= 1'b1;
      coreResult <= sample;
      cnt <= 8'h06;
    end else if (coreDone) begin
      // result is only promised while done is high
      coreDone <= 1'b0;
      coreResult <= ~coreResult;
    end
  end
endmodule // adcpc_core_model

//--- test/test_adc_conversion_power_control.sv
`timescale 1ns/1ps
`include "adcpc_defines.vh"

module test_adc_conversion_power_control;
  reg mclk = 1'b0, reset_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  reg arvalid = 1'b0, stopMode = 1'b0, breakState = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00, lat = 8'h04, k;
  reg [31:0] wdata = 32'h0;
  reg [9:0] sample = 10'h2A5;
  wire awready, wready, bvalid, arready, rvalid, coreDone, coreStart;
  wire coreAbort, coreLowPower, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [9:0] coreResult;
  wire [4:0] coreChannel;
  integer failures = 0, n_checks = 0, nStart = 0, nAbort = 0, s0, a0;
  adcpc_top DUT (.mclk(mclk), .reset_n(reset_n), .awaddr(awaddr),
    .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(1'b1), .stopMode(stopMode),
    .breakState(breakState), .coreDone(coreDone), .coreResult(coreResult),
    .coreStart(coreStart), .coreAbort(coreAbort),
    .coreLowPower(coreLowPower), .coreChannel(coreChannel), .irq(irq));
  adcpc_core_model core (.mclk(mclk), .reset_n(reset_n),
    .coreStart(coreStart), .coreAbort(coreAbort), .lat(lat),
    .sample(sample), .coreDone(coreDone), .coreResult(coreResult));
  initial begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    nStart <= nStart + coreStart;
    nAbort <= nAbort + coreAbort;
  end
  // ------------------------------------------------
  // bus cycles and comparison
  // ------------------------------------------------
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // ready lines are sampled before the edge lands
  task wr(input [7:0] a, input [31:0] d);
    reg pend;
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      pend = 1'b1;
      while (pend) begin
        @(posedge mclk);
        pend = (awvalid & ~awready) | (wvalid & ~wready);
        awvalid <= awvalid & ~awready;
        wvalid <= wvalid & ~wready;
      end
      do @(posedge mclk); while (!bvalid);
      chk(bresp, a > `ADCPC_OFS_BFC ? `ADCPC_RESP_SLVERR : `ADCPC_RESP_OKAY);
      repeat (2) @(posedge mclk);
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge mclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge mclk); while (!rvalid);
      chk(rdata, e);
      chk(rresp, a > `ADCPC_OFS_BFC ? `ADCPC_RESP_SLVERR : `ADCPC_RESP_OKAY);
      @(posedge mclk);
    end
  endtask
  task waitConv;
    integer i;
    begin
      i = 0;
      while (!coreDone && i < 500) begin
        @(posedge mclk);
        i = i + 1;
      end
      chk(coreDone, 1'b1);
      repeat (8) @(posedge mclk);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #3000000;
    failures = failures + 1;
    give_verdict;
  end
  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    for (k = 8'h00; k < 8'h18; k = k + 8'h04)
      rdc(k, {27'h0, {5{k == 8'h00}}});
    $display("test reset values done");
    wr(`ADCPC_OFS_SC, 32'h01);
    chk(coreChannel, 32'h01);
    waitConv;
    chk(irq, 1'b0);
    rdc(`ADCPC_OFS_SC, 32'h81);
    rdc(`ADCPC_OFS_RESHI, 32'h2);
    rdc(`ADCPC_OFS_RESLO, 32'hA5);
    rdc(`ADCPC_OFS_SC, 32'h01);
    wr(`ADCPC_OFS_SC, 32'h41);
    waitConv;
    chk(irq, 1'b1);
    chk(coreLowPower, 1'b1);
    rdc(`ADCPC_OFS_RESLO, 32'hA5);
    chk(irq, 1'b0);
    $display("test completion flag done");
    wr(`ADCPC_OFS_SC, 32'h41);
    waitConv;
    s0 = nStart;
    wr(`ADCPC_OFS_SC, 32'h5F);
    chk(irq, 1'b0);
    chk(nStart, s0);
    chk(coreLowPower, 1'b1);
    chk(coreChannel, 32'h1F);
    wr(8'h14, 32'h01);
    chk(nStart, s0);
    $display("test channel off done");
    sample <= 10'h0F0;
    lat <= 8'h40;
    wr(`ADCPC_OFS_SC, 32'h61);
    repeat (4) @(posedge mclk);
    s0 = nStart;
    a0 = nAbort;
    wr(`ADCPC_OFS_SC, 32'h61);
    chk(nStart, s0 + 1);
    chk(nAbort, a0 + 1);
    stopMode <= 1'b1;
    repeat (6) @(posedge mclk);
    chk(nAbort, a0 + 2);
    chk(coreLowPower, 1'b1);
    stopMode <= 1'b0;
    repeat (100) @(posedge mclk);
    chk(nStart, s0 + 1);
    rdc(`ADCPC_OFS_RESHI, 32'h2);
    rdc(`ADCPC_OFS_RESLO, 32'hA5);
    lat <= 8'h10;
    wr(`ADCPC_OFS_SC, 32'h01);
    waitConv;
    rdc(`ADCPC_OFS_RESLO, 32'hF0);
    $display("test stop abort done");
    wr(`ADCPC_OFS_CLK, 32'h01);
    a0 = nAbort;
    wr(`ADCPC_OFS_SC, 32'h41);
    stopMode <= 1'b1;
    waitConv;
    chk(irq, 1'b1);
    chk(nAbort, a0);
    stopMode <= 1'b0;
    breakState <= 1'b1;
    repeat (3) @(posedge mclk);
    $display("test async clock stop done");
    rdc(`ADCPC_OFS_RESLO, 32'hF0);
    chk(irq, 1'b1);
    wr(`ADCPC_OFS_BFC, 32'h01);
    rdc(`ADCPC_OFS_RESLO, 32'hF0);
    chk(irq, 1'b0);
    breakState <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(irq, 1'b0);
    $display("test break protection done");
    s0 = nStart;
    wr(`ADCPC_OFS_CLK, 32'h07);
    stopMode <= 1'b1;
    repeat (30) @(posedge mclk);
    chk(nStart, s0);
    $display("test hardware trigger done");
    give_verdict;
  end
endmodule // test_adc_conversion_power_control

bind adcpc_top adcpc_top_assertions u_chk (.mclk(mclk), .reset_n(reset_n),
  .araddr(araddr), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .bvalid(bvalid),
  .breakState(breakState), .coreDone(coreDone), .coreStart(coreStart),
  .coreAbort(coreAbort), .coreLowPower(coreLowPower), .irq(irq));
